// ### inc/rtc_timekeeper_pkg.sv
// Register map, field layout and divider constants of the real-time clock timekeeper.
package rtc_timekeeper_pkg;
	localparam int          ADDR_W          = 16;
	localparam int          DATA_W          = 8;
	localparam int          DIV_W           = 16;
	// Register offsets in processor I/O space.
	localparam logic [15:0] OFS_SEC         = 16'h00E0;
	localparam logic [15:0] OFS_MIN         = 16'h00E1;
	localparam logic [15:0] OFS_HRS         = 16'h00E2;
	localparam logic [15:0] OFS_DOW         = 16'h00E3;
	localparam logic [15:0] OFS_CENTURY     = 16'h00E7;
	localparam logic [15:0] OFS_ALARM_SECONDS = 16'h00E8;
	localparam logic [15:0] OFS_AMIN        = 16'h00E9;
	localparam logic [15:0] OFS_AHRS        = 16'h00EA;
	localparam logic [15:0] OFS_ADOW        = 16'h00EB;
	localparam logic [15:0] OFS_ACTRL       = 16'h00EC;
	localparam logic [15:0] OFS_CTRL        = 16'h00ED;
	// Control register fields.
	localparam int          CTRL_UNLOCK     = 0;
	localparam int          CTRL_LINE60     = 1;
	localparam int          CTRL_LINESEL    = 2;
	localparam int          CTRL_BCD        = 3;
	localparam int          CTRL_INTEN      = 4;
	localparam int          CTRL_ALARM      = 7;
	// Alarm enable fields.
	localparam int          AEN_SEC         = 0;
	localparam int          AEN_MIN         = 1;
	localparam int          AEN_HRS         = 2;
	localparam int          AEN_DOW         = 3;
	localparam int          AEN_W           = 4;
	// Values after reset.
	localparam logic        RST_UNLOCK      = 1'b0;
	localparam logic [3:0]  RST_AEN         = 4'h0;
	localparam logic [7:0]  RST_RDDATA      = 8'h00;
	// Count ranges, binary values.
	localparam int          SEC_MAX         = 59;
	localparam int          MIN_MAX         = 59;
	localparam int          HRS_MAX         = 23;
	localparam int          DOW_MIN         = 1;
	localparam int          DOW_MAX         = 7;
	// Source edges per one-second tick.
	localparam int          OSC_DIV_DEFAULT = 32768;
	localparam int          LINE50_DIV      = 50;
	localparam int          LINE60_DIV      = 60;
endpackage

// ### src/rtc_count_unit.sv
// One time field that counts in binary or packed BCD and wraps at its limit.
`timescale 1ns/1ps
module rtc_count_unit #(
	parameter int MINV = 0,
	parameter int MAXV = 59
)(
	// Clock.
	input  wire logic       clk,
	input  wire logic       rstn,
	// Control.
	input  wire logic       bcdEn,
	input  wire logic       inc,
	input  wire logic       load,
	input  wire logic [7:0] loadData,
	// State.
	output logic      [7:0] value,
	output logic            atMax
);
	localparam logic [7:0] MAX_BIN = 8'(MAXV);
	localparam logic [7:0] MAX_BCD = 8'((MAXV / 10) * 16 + (MAXV % 10));
	localparam logic [7:0] MIN_ENC = 8'(MINV);

	logic [7:0] next_value;
	logic [7:0] bcdStep;

	assign atMax   = value == (bcdEn ? MAX_BCD : MAX_BIN);
	assign bcdStep = (value[3:0] == 4'h9) ? {4'(value[7:4] + 4'h1), 4'h0} : 8'(value + 8'h01);
	assign next_value = load ? loadData : atMax ? MIN_ENC : bcdEn ? bcdStep : 8'(value + 8'h01);

	// Counts are kept through reset, so this register has no reset branch.
	always_ff @(posedge clk) begin
		if (load || inc) begin
			value <= next_value;
		end
	end

	wrap_to_min_a: assert property (@(posedge clk) disable iff (!rstn)
		inc && !load && atMax |=> value == MIN_ENC)
		else $error("count did not wrap to its minimum");
	bcd_carry_a: assert property (@(posedge clk) disable iff (!rstn)
		inc && !load && !atMax && bcdEn && value[3:0] == 4'h9 |=> value[3:0] == 4'h0)
		else $error("BCD ones digit did not carry");
endmodule

// ### src/rtc_tick_divider.sv
// Synchronises the timekeeping source pins and divides the chosen one to one-second ticks.
`timescale 1ns/1ps
module rtc_tick_divider #(
	parameter int OSC_DIV = rtc_timekeeper_pkg::OSC_DIV_DEFAULT
)(
	// Clock.
	input  wire logic clk,
	input  wire logic rstn,
	// Source pins.
	input  wire logic oscPin,
	input  wire logic linePin,
	// Control.
	input  wire logic lineSel,
	input  wire logic line60,
	input  wire logic restart,
	input  wire logic hold,
	// Tick.
	output logic      tick
);
	import rtc_timekeeper_pkg::*;

	logic [2:0]       oscSync;
	logic [2:0]       lineSync;
	logic [DIV_W-1:0] divCount;
	logic [DIV_W-1:0] terminal;
	logic             srcEdge;

	assign srcEdge  = lineSel ? (lineSync[1] & ~lineSync[2]) : (oscSync[1] & ~oscSync[2]);
	assign terminal = lineSel ? (line60 ? DIV_W'(LINE60_DIV - 1) : DIV_W'(LINE50_DIV - 1))
	                          : DIV_W'(OSC_DIV - 1);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			oscSync  <= 3'h0;
			lineSync <= 3'h0;
		end else begin
			oscSync  <= {oscSync[1:0], oscPin};
			lineSync <= {lineSync[1:0], linePin};
		end
	end

	// A held or restarted divider starts a fresh phase so the first tick is a full second away.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			divCount <= '0;
			tick     <= 1'b0;
		end else if (restart || hold) begin
			divCount <= '0;
			tick     <= 1'b0;
		end else begin
			tick <= srcEdge && divCount == terminal;
			if (srcEdge) begin
				divCount <= (divCount == terminal) ? '0 : DIV_W'(divCount + 1'b1);
			end
		end
	end

	divider_restart_a: assert property (@(posedge clk) disable iff (!rstn)
		restart |=> divCount == '0 && !tick)
		else $error("divider not restarted");
	hold_no_tick_a: assert property (@(posedge clk) disable iff (!rstn)
		hold |=> !tick)
		else $error("tick while divider held");
endmodule

// ### src/rtc_alarm_timekeeper.sv
// Real-time clock timekeeper with write-protected counts, alarm matching and I/O register access.
// Behaviour
// - Alarm fires when every enabled set-point matches.
// - Alarm sets flag; interrupt only when enabled.
// - Reading control clears flag and interrupt.
// - Alarm registers writable regardless of lock.
// - Compare alarm each one-second count increment.
// - Writing unlock zero forces an alarm compare.
// - Source is oscillator or 50/60 Hz line.
// - Any control write restarts the divider.
// - Power-up reset disables all alarm enables.
// - Clearing unlock restarts then enables divider.
// - Unlocked stops counting; locked makes counts read-only.
// - Reset leaves counts locked and running.
// - Reset leaves count and alarm values untouched.
// - Decimal select chooses binary or packed BCD.
// - Seconds range 0-59, BCD tens 0-5.
// - Century range 0-99 in either coding.
// - Alarm seconds always read/write, seconds coding.
// - Registers reached through processor I/O cycles.
`timescale 1ns/1ps
module rtc_alarm_timekeeper #(
	parameter int OSC_DIV = rtc_timekeeper_pkg::OSC_DIV_DEFAULT
)(
	// Clock and reset.
	input  wire logic                                   clk,
	input  wire logic                                   rstn,
	// Processor I/O bus.
	input  wire logic [rtc_timekeeper_pkg::ADDR_W-1:0]  ioAddr,
	input  wire logic [rtc_timekeeper_pkg::DATA_W-1:0]  ioWrData,
	input  wire logic                                   ioWr,
	input  wire logic                                   ioRd,
	output logic      [rtc_timekeeper_pkg::DATA_W-1:0]  ioRdData,
	// Timekeeping source pins.
	input  wire logic                                   oscClkPin,
	input  wire logic                                   lineFreqPin,
	// Interrupt request.
	output logic                                        alarmIrq
);
	import rtc_timekeeper_pkg::*;

	// Control state.
	logic              unlock;
	logic              line60;
	logic              lineSel;
	logic              bcdEn;
	logic              intEn;
	logic              alarmFlag;
	logic [AEN_W-1:0]  alarmEn;
	// Set-points and the century count.
	logic [7:0]        alarmSec;
	logic [7:0]        alarmMin;
	logic [7:0]        alarmHrs;
	logic [7:0]        alarmDow;
	logic [7:0]        century;
	// Running counts.
	logic [7:0]        secVal;
	logic [7:0]        minVal;
	logic [7:0]        hrsVal;
	logic [7:0]        dowVal;
	logic              secMax;
	logic              minMax;
	logic              hrsMax;
	logic              tick;
	logic              tickD;

	// Address decode.
	wire               selSec   = ioAddr == OFS_SEC;
	wire               selMin   = ioAddr == OFS_MIN;
	wire               selHrs   = ioAddr == OFS_HRS;
	wire               selDow   = ioAddr == OFS_DOW;
	wire               selCentury = ioAddr == OFS_CENTURY;
	wire               selAlmSec  = ioAddr == OFS_ALARM_SECONDS;
	wire               selAmin  = ioAddr == OFS_AMIN;
	wire               selAhrs  = ioAddr == OFS_AHRS;
	wire               selAdow  = ioAddr == OFS_ADOW;
	wire               selActrl = ioAddr == OFS_ACTRL;
	wire               selCtrl  = ioAddr == OFS_CTRL;

	// Count writes are honoured only while unlocked; alarm writes always are.
	wire               cntWr    = ioWr && unlock;
	wire               wrCtrl   = ioWr && selCtrl;
	wire               rdCtrl   = ioRd && selCtrl;
	wire               run      = !unlock;

	// Count chain: each field advances when all lower fields wrap on the same tick.
	wire               incSec   = tick && run;
	wire               incMin   = incSec && secMax;
	wire               incHrs   = incMin && minMax;
	wire               incDow   = incHrs && hrsMax;

	// Alarm matching across the enabled fields.
	wire [AEN_W-1:0]   fieldHit = {dowVal == alarmDow, hrsVal == alarmHrs,
	                               minVal == alarmMin, secVal == alarmSec};
	wire               alarmMatch = (|alarmEn) && ((fieldHit | ~alarmEn) == {AEN_W{1'b1}});
	wire               forceCmp = wrCtrl && !ioWrData[CTRL_UNLOCK];
	wire               compareNow = tickD || forceCmp;
	wire               setAlarm = compareNow && alarmMatch;
	// A new alarm in the cycle of a control read survives the read.
	wire               next_alarmFlag = setAlarm || (alarmFlag && !rdCtrl);

	wire [7:0]         ctrlView = {alarmFlag, 2'h0, intEn, bcdEn, lineSel, line60, unlock};
	wire [7:0]         actrlView = {4'h0, alarmEn};
	wire [7:0]         rdMux =
		selSec   ? secVal   :
		selMin   ? minVal   :
		selHrs   ? hrsVal   :
		selDow   ? dowVal   :
		selCentury ? century  :
		selAlmSec  ? alarmSec :
		selAmin  ? alarmMin :
		selAhrs  ? alarmHrs :
		selAdow  ? alarmDow :
		selActrl ? actrlView :
		selCtrl  ? ctrlView : 8'h00;

	rtc_tick_divider #(
		.OSC_DIV (OSC_DIV)
	) u_divider (
		.clk     (clk),
		.rstn    (rstn),
		.oscPin  (oscClkPin),
		.linePin (lineFreqPin),
		.lineSel (lineSel),
		.line60  (line60),
		.restart (wrCtrl),
		.hold    (unlock),
		.tick    (tick)
	);

	rtc_count_unit #(
		.MINV (0),
		.MAXV (SEC_MAX)
	) u_sec (
		.clk      (clk),
		.rstn     (rstn),
		.bcdEn    (bcdEn),
		.inc      (incSec),
		.load     (cntWr && selSec),
		.loadData (ioWrData),
		.value    (secVal),
		.atMax    (secMax)
	);

	rtc_count_unit #(
		.MINV (0),
		.MAXV (MIN_MAX)
	) u_min (
		.clk      (clk),
		.rstn     (rstn),
		.bcdEn    (bcdEn),
		.inc      (incMin),
		.load     (cntWr && selMin),
		.loadData (ioWrData),
		.value    (minVal),
		.atMax    (minMax)
	);

	rtc_count_unit #(
		.MINV (0),
		.MAXV (HRS_MAX)
	) u_hrs (
		.clk      (clk),
		.rstn     (rstn),
		.bcdEn    (bcdEn),
		.inc      (incHrs),
		.load     (cntWr && selHrs),
		.loadData (ioWrData),
		.value    (hrsVal),
		.atMax    (hrsMax)
	);

	rtc_count_unit #(
		.MINV (DOW_MIN),
		.MAXV (DOW_MAX)
	) u_dow (
		.clk      (clk),
		.rstn     (rstn),
		.bcdEn    (bcdEn),
		.inc      (incDow),
		.load     (cntWr && selDow),
		.loadData (ioWrData),
		.value    (dowVal),
		.atMax    ()
	);

	// Set-points and century hold their contents through reset.
	always_ff @(posedge clk) begin
		if (ioWr && selAlmSec) begin
			alarmSec <= ioWrData;
		end
		if (ioWr && selAmin) begin
			alarmMin <= ioWrData;
		end
		if (ioWr && selAhrs) begin
			alarmHrs <= ioWrData;
		end
		if (ioWr && selAdow) begin
			alarmDow <= ioWrData;
		end
		if (cntWr && selCentury) begin
			century <= ioWrData;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			unlock  <= RST_UNLOCK;
			line60  <= 1'b0;
			lineSel <= 1'b0;
			bcdEn   <= 1'b0;
			intEn   <= 1'b0;
		end else if (wrCtrl) begin
			unlock  <= ioWrData[CTRL_UNLOCK];
			line60  <= ioWrData[CTRL_LINE60];
			lineSel <= ioWrData[CTRL_LINESEL];
			bcdEn   <= ioWrData[CTRL_BCD];
			intEn   <= ioWrData[CTRL_INTEN];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			alarmEn <= RST_AEN;
		end else if (ioWr && selActrl) begin
			alarmEn <= ioWrData[AEN_W-1:0];
		end
	end

	// The interrupt follows the flag only through the enable, and the read clears both at once.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			alarmFlag <= 1'b0;
			alarmIrq  <= 1'b0;
			tickD     <= 1'b0;
		end else begin
			alarmFlag <= next_alarmFlag;
			alarmIrq  <= next_alarmFlag && intEn;
			tickD     <= incSec;
		end
	end

	// Read data is captured on the strobe and stands until the next read.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ioRdData <= RST_RDDATA;
		end else if (ioRd) begin
			ioRdData <= rdMux;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_tickCompare;
		incSec ##1 alarmMatch;
	endsequence

	sequence s_forcedCompare;
		forceCmp && alarmMatch;
	endsequence

	tick_match_a: assert property (s_tickCompare |=> alarmFlag)
		else $error("alarm missed on a matching tick");
	forced_match_a: assert property (s_forcedCompare |=> alarmFlag)
		else $error("forced compare did not raise alarm");
	no_false_alarm_a: assert property (!alarmFlag && !(compareNow && alarmMatch) |=> !alarmFlag)
		else $error("alarm raised without a match");
	no_enable_quiet_a: assert property (alarmEn == '0 && !alarmFlag |=> !alarmFlag)
		else $error("alarm raised with every enable off");
	irq_gated_a: assert property (alarmIrq |-> $past(intEn) && alarmFlag)
		else $error("interrupt without enable or flag");
	irq_follow_a: assert property (setAlarm && intEn |=> alarmIrq)
		else $error("enabled alarm gave no interrupt");
	read_clear_a: assert property (rdCtrl && !setAlarm |=> !alarmFlag && !alarmIrq)
		else $error("control read did not clear alarm");
	// Counts are undefined until software sets them, so stability is judged by case equality.
	locked_count_a: assert property (run && !incSec |=> secVal === $past(secVal))
		else $error("locked seconds changed without a tick");
	unlocked_still_a: assert property (unlock && !ioWr |=> secVal === $past(secVal) && minVal === $past(minVal))
		else $error("counts moved while unlocked");
	reset_locked_a: assert property (@(posedge clk) disable iff (1'b0) !rstn |-> !unlock)
		else $error("reset left counts unlocked");
	alarm_enable_reset_a: assert property (@(posedge clk) disable iff (1'b0) !rstn |-> alarmEn == '0)
		else $error("reset left an alarm enabled");
	alarm_write_a: assert property (ioWr && selAlmSec |=> alarmSec == $past(ioWrData))
		else $error("alarm seconds write lost");
	sec_step_a: assert property (incSec && !bcdEn && !secMax |=> secVal == 8'($past(secVal) + 8'h01))
		else $error("binary seconds did not advance by one");
	count_load_a: assert property (cntWr && selSec |=> secVal == $past(ioWrData))
		else $error("unlocked seconds write lost");
	century_locked_a: assert property (ioWr && selCentury && !unlock |=> century === $past(century))
		else $error("locked century was overwritten");
	ctrl_write_a: assert property (wrCtrl |=> unlock == $past(ioWrData[CTRL_UNLOCK]) && bcdEn == $past(ioWrData[CTRL_BCD]))
		else $error("control write not taken");
	read_data_a: assert property (ioRd |=> ioRdData == $past(rdMux))
		else $error("read data not captured");
	irq_disabled_a: assert property (!intEn |=> !alarmIrq)
		else $error("interrupt raised while disabled");
endmodule

// ### tb/rtc_alarm_timekeeper_tb_top.sv
// Self-checking testbench of the real-time clock timekeeper, driven from its register and source pins.
`timescale 1ns/1ps
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin errorCnt++; \
	$display("unexpected at %0t: got %h, expected %h", $time, (g), (e)); end end
module rtc_alarm_timekeeper_tb_top;
	import rtc_timekeeper_pkg::*;
	// A short divider keeps each oscillator one-second tick to a few dozen clock cycles.
	localparam int       SIM_DIV = 4;
	localparam int       MAX_CYC = 30000;
	logic                clk;
	logic                rstn;
	logic [ADDR_W-1:0]   ioAddr;
	logic [DATA_W-1:0]   ioWrData;
	logic                ioWr;
	logic                ioRd;
	logic [DATA_W-1:0]   ioRdData;
	logic                oscClkPin;
	logic                lineFreqPin;
	logic                alarmIrq;
	int                  errorCnt;
	int                  nCompared;
	int                  cycles;
	logic [31:0]         rng;
	logic [7:0]          rdVal;
	logic [7:0]          secVal;
	logic [7:0]          ctrlVal;

	rtc_alarm_timekeeper #(.OSC_DIV(SIM_DIV)) i_dut (
		.clk         (clk),
		.rstn        (rstn),
		.ioAddr      (ioAddr),
		.ioWrData    (ioWrData),
		.ioWr        (ioWr),
		.ioRd        (ioRd),
		.ioRdData    (ioRdData),
		.oscClkPin   (oscClkPin),
		.lineFreqPin (lineFreqPin),
		.alarmIrq    (alarmIrq)
	);

	always #2 clk = ~clk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction

	// Next seconds or minutes value, wrapping at 59 in the chosen coding.
	function automatic logic [7:0] secInc(input logic [7:0] v, input logic bcd);
		if (bcd) begin
			if (v == 8'h59)
				return 8'h00;
			return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
		end
		return (v == 8'h3B) ? 8'h00 : v + 8'h01;
	endfunction

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		ioAddr   <= a;
		ioWrData <= d;
		ioWr     <= 1'b1;
		@(posedge clk);
		ioWr     <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a);
		@(posedge clk);
		ioAddr <= a;
		ioRd   <= 1'b1;
		@(posedge clk);
		ioRd   <= 1'b0;
		#1;
		rdVal = ioRdData;
	endtask

	// Slow source edges; the settle time lets the synchroniser and the count update land.
	task automatic edges(input int n, input logic line);
		repeat (n) begin
			@(posedge clk);
			oscClkPin   <= ~line;
			lineFreqPin <= line;
			repeat (3) @(posedge clk);
			oscClkPin   <= 1'b0;
			lineFreqPin <= 1'b0;
			repeat (3) @(posedge clk);
		end
		repeat (8) @(posedge clk);
	endtask

	task automatic stop_test();
		$display("errors %0d, comparisons %0d", errorCnt, nCompared);
		if (errorCnt == 0 && nCompared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == MAX_CYC) begin
			errorCnt++;
			stop_test();
		end
	end

	initial begin
		clk = 1'b0; rstn = 1'b0; ioAddr = 16'h0000; ioWrData = 8'h00; ioWr = 1'b0; ioRd = 1'b0;
		oscClkPin = 1'b0; lineFreqPin = 1'b0; errorCnt = 0; nCompared = 0; cycles = 0;
		rng = 32'hD20FA414;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		rd(OFS_CTRL); `CHK(rdVal, 8'h00)
		rd(OFS_ACTRL); `CHK(rdVal, 8'h00)
		rd(16'h00F0); `CHK(rdVal, 8'h00)
		// Recommended bring-up: unlock, set time, then lock again.
		wr(OFS_CTRL, 8'h01);
		wr(OFS_SEC, 8'h3B);
		wr(OFS_MIN, 8'h0A);
		wr(OFS_HRS, 8'h00);
		wr(OFS_DOW, 8'h01);
		wr(OFS_CENTURY, 8'h63);
		rd(OFS_SEC); `CHK(rdVal, 8'h3B)
		rd(OFS_CENTURY); `CHK(rdVal, 8'h63)
		wr(OFS_CTRL, 8'h00);
		wr(OFS_SEC, 8'h11);
		wr(OFS_CENTURY, 8'h00);
		rd(OFS_SEC); `CHK(rdVal, 8'h3B)
		rd(OFS_CENTURY); `CHK(rdVal, 8'h63)
		edges(SIM_DIV - 1, 1'b0);
		rd(OFS_SEC); `CHK(rdVal, 8'h3B)
		edges(1, 1'b0);
		rd(OFS_SEC); `CHK(rdVal, 8'h00)
		rd(OFS_MIN); `CHK(rdVal, 8'h0B)
		// A control write part-way through a second restarts the divider.
		edges(SIM_DIV - 1, 1'b0);
		wr(OFS_CTRL, 8'h00);
		edges(SIM_DIV - 1, 1'b0);
		rd(OFS_SEC); `CHK(rdVal, 8'h00)
		edges(1, 1'b0);
		rd(OFS_SEC); `CHK(rdVal, 8'h01)
		wr(OFS_CTRL, 8'h01);
		edges(2 * SIM_DIV, 1'b0);
		rd(OFS_SEC); `CHK(rdVal, 8'h01)
		wr(OFS_ACTRL, 8'h01);
		// Forced compares at random seconds, interrupt enable off then on.
		for (int i = 0; i < 4; i++) begin
			rng = xs(rng);
			secVal = 8'(rng % 60);
			ctrlVal = (i == 0) ? 8'h00 : 8'h10;
			wr(OFS_CTRL, 8'h01);
			wr(OFS_SEC, secVal);
			wr(OFS_ALARM_SECONDS, secVal);
			rd(OFS_ALARM_SECONDS); `CHK(rdVal, secVal)
			wr(OFS_CTRL, ctrlVal);
			repeat (2) @(posedge clk);
			#1;
			`CHK(alarmIrq, (i != 0))
			rd(OFS_CTRL); `CHK(rdVal, 8'h80 | ctrlVal)
			`CHK(alarmIrq, 1'b0)
			rd(OFS_CTRL); `CHK(rdVal, ctrlVal)
		end
		// Every enabled field must match; alarm registers written while locked.
		wr(OFS_AMIN, 8'h0C);
		wr(OFS_ACTRL, 8'h03);
		wr(OFS_CTRL, 8'h00);
		rd(OFS_CTRL); `CHK(rdVal, 8'h00)
		wr(OFS_AMIN, 8'h0B);
		wr(OFS_CTRL, 8'h00);
		rd(OFS_CTRL); `CHK(rdVal, 8'h80)
		wr(OFS_ACTRL, 8'h01);
		secVal = secInc(secVal, 1'b0);
		wr(OFS_ALARM_SECONDS, secVal);
		rd(OFS_CTRL); `CHK(rdVal, 8'h00)
		edges(SIM_DIV, 1'b0);
		rd(OFS_CTRL); `CHK(rdVal, 8'h80)
		// Packed decimal counting with a carry into minutes.
		wr(OFS_ACTRL, 8'h00);
		wr(OFS_CTRL, 8'h09);
		wr(OFS_SEC, 8'h58);
		wr(OFS_MIN, 8'h09);
		wr(OFS_CTRL, 8'h08);
		secVal = 8'h58;
		for (int k = 0; k < 3; k++) begin
			edges(SIM_DIV, 1'b0);
			secVal = secInc(secVal, 1'b1);
			rd(OFS_SEC); `CHK(rdVal, secVal)
		end
		rd(OFS_MIN); `CHK(rdVal, 8'h10)
		// Line source at 50 and at 60 edges per second.
		for (int m = 0; m < 2; m++) begin
			wr(OFS_CTRL, (m == 0) ? 8'h04 : 8'h06);
			edges(((m == 0) ? LINE50_DIV : LINE60_DIV) - 1, 1'b1);
			rd(OFS_SEC); `CHK(rdVal, secVal)
			edges(1, 1'b1);
			secVal = secInc(secVal, 1'b0);
			rd(OFS_SEC); `CHK(rdVal, secVal)
		end
		// A second reset keeps counts and set-points but clears the enables.
		wr(OFS_ALARM_SECONDS, 8'h2A);
		wr(OFS_ACTRL, 8'h0F);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		rd(OFS_SEC); `CHK(rdVal, secVal)
		rd(OFS_ALARM_SECONDS); `CHK(rdVal, 8'h2A)
		rd(OFS_ACTRL); `CHK(rdVal, 8'h00)
		rd(OFS_CTRL); `CHK(rdVal, 8'h00)
		stop_test();
	end
endmodule
